// ---- hdl/cqm_pkg.sv ----
// Constants shared by the channel quality metrics block
package cqm_pkg;
  // Datapath widths
  localparam int PAIRS = 4; // Cable pairs measured
  localparam int CH_W = 2; // Pair number width
  localparam int ERR_W = 8; // Signed slicer error width
  localparam int MAG_W = 7; // Clamped magnitude width
  localparam int SQ_W = 13; // Squared magnitude width
  localparam int FRAC_W = 16; // Filter fraction bits
  localparam int ACC_W = SQ_W + FRAC_W; // Filter accumulator width
  localparam int SH_W = 4; // Gain and scale shift fields
  localparam int TH_W = 9; // Threshold and mean square error width
  localparam int TH_N = 7; // Quality thresholds
  localparam int IDX_W = 3; // Quality index width
  localparam int PK_W = 6; // Peak error width
  localparam int WIN_W = 17; // Window counter width
  // Limits and scaling
  localparam logic [MAG_W-1:0] MAG_LIMIT = 7'h40; // Largest slicer error after doubling
  localparam logic [TH_W-1:0] MSE_MAX = 9'h1ff; // Mean square error ceiling
  localparam logic [PK_W-1:0] PEAK_MAX = 6'h3f; // Peak error ceiling
  localparam logic [SH_W:0] PEAK_EXTRA_SHIFT = 5'h03; // Extra peak divide
  localparam logic [IDX_W-1:0] IDX_WORST = 3'h0; // Poorest quality
  localparam logic [IDX_W-1:0] IDX_BEST = 3'h7; // Best quality
  // Measurement window: 1.0 ms of 125 symbols per microsecond
  localparam int WINDOW_TIME_US = 1000;
  localparam int SYMBOLS_PER_US = 125;
  localparam int WINDOW_SYMBOLS = WINDOW_TIME_US * SYMBOLS_PER_US;
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MSE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MSE_WORST = 8'h08;
  localparam logic [ADDR_W-1:0] REG_QUALITY = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_MEAN_ERR = 8'h10;
  localparam logic [ADDR_W-1:0] REG_PEAK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_TH_BASE = 8'h20; // Threshold n at base + 4*(n-1)
  // Configuration field positions
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_SQ_BIT = 1;
  localparam int CFG_CH_LSB = 2;
  localparam int CFG_CAP_BIT = 4;
  localparam int CFG_AVG_LSB = 8;
  localparam int CFG_PKG_LSB = 12;
  localparam int CFG_MSES_LSB = 16;
  localparam int CFG_PKS_LSB = 20;
  localparam int QUAL_WORST_LSB = 4;
  localparam int PEAK_WORST_LSB = 8;
  // Reset values
  localparam logic [TH_W-1:0] TH_RST = 9'h000;
  localparam logic [SH_W-1:0] SHIFT_RST = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cqm_pkg

// ---- hdl/cqm_pair_filter.sv ----
// Per-pair slicer error filters with 1 ms window capture
`timescale 1ns/1ps
module cqm_pair_filter
  import cqm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic enable_in,
  input wire logic square_in,
  input wire logic gig_in,
  input wire logic sample_valid_in,
  input wire logic signed [ERR_W-1:0] slicer_err_in,
  input wire logic [SH_W-1:0] average_gain_shift_in,
  input wire logic [SH_W-1:0] peak_gain_shift_in,
  input wire logic window_tick_in,
  output logic [SQ_W-1:0] avg_saved_out,
  output logic [SQ_W-1:0] peak_saved_out
);
  // All state of one pair
  typedef struct packed {
    logic [ACC_W-1:0] avg_acc; // Averaging filter
    logic [ACC_W-1:0] pk_acc; // Peak filter
    logic [SQ_W-1:0] pk_run; // Highest peak filter value this window
    logic [SQ_W-1:0] avg_saved; // Averaging value at last window end
    logic [SQ_W-1:0] pk_saved; // Peak value at last window end
  } cqm_pair_state_type;

  cqm_pair_state_type s_ff;
  cqm_pair_state_type nxt_s;

  // One low-pass step: add back (x - acc) / 2^shift
  function automatic logic [ACC_W-1:0] filt_step(input logic [ACC_W-1:0] acc,
      input logic [SQ_W-1:0] x, input logic [SH_W-1:0] sh);
    logic signed [ACC_W:0] d;
    logic signed [ACC_W:0] r;
    d = $signed({1'b0, x, {FRAC_W{1'b0}}}) - $signed({1'b0, acc});
    r = $signed({1'b0, acc}) + (d >>> sh);
    return r[ACC_W-1:0];
  endfunction : filt_step

  // Next state
  always_comb begin
    logic [ERR_W:0] mag;
    logic [MAG_W-1:0] lim;
    logic [SQ_W-1:0] x;
    logic [SQ_W-1:0] pk_now;
    mag = '0;
    lim = '0;
    x = '0;
    pk_now = '0;
    nxt_s = s_ff;
    // Magnitude, doubled at gigabit before any squaring
    mag = {1'b0, (slicer_err_in[ERR_W-1] ? ERR_W'(-slicer_err_in) : slicer_err_in)};
    if (gig_in) begin
      mag = {mag[ERR_W-1:0], 1'b0};
    end
    // Clamp to the legal error span so the square fits
    lim = (mag > {2'h0, MAG_LIMIT}) ? MAG_LIMIT : mag[MAG_W-1:0];
    // Widen before multiplying: a 7-bit product would lose the square
    x = square_in ? SQ_W'(lim) * SQ_W'(lim) : {{(SQ_W-MAG_W){1'b0}}, lim};
    if (!enable_in) begin
      // Idle and cleared while disabled
      nxt_s = '0;
    end else begin
      if (sample_valid_in) begin
        nxt_s.avg_acc = filt_step(s_ff.avg_acc, x, average_gain_shift_in);
        nxt_s.pk_acc = filt_step(s_ff.pk_acc, x, peak_gain_shift_in);
      end
      pk_now = nxt_s.pk_acc[ACC_W-1:FRAC_W];
      if (pk_now > s_ff.pk_run) begin
        nxt_s.pk_run = pk_now;
      end
      if (window_tick_in) begin
        // Save both filters and open a fresh peak window
        nxt_s.avg_saved = nxt_s.avg_acc[ACC_W-1:FRAC_W];
        nxt_s.pk_saved = nxt_s.pk_run;
        nxt_s.pk_run = '0;
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_ff <= '0;
    end else if (clk_en_in) begin
      s_ff <= nxt_s;
    end
  end

  assign avg_saved_out = s_ff.avg_saved;
  assign peak_saved_out = s_ff.pk_saved;
endmodule : cqm_pair_filter

// ---- hdl/cqm_top.sv ----
// Channel quality metrics with AXI4-Lite registers
//
// Overview of operation
// - Method A maps error to index 0..7
// - Index is highest n with error within threshold
// - All measurements run only while enabled
// - Mean square error scaled by shift, capped 511
// - Capture bit self-clears, loads selected pair index
// - Keep lowest index since last read
// - Method B filters absolute slicer error
// - Add back difference; double error at gigabit
// - Add-back divided by two to average gain
// - Square mode squares scaled error before filtering
// - Capture loads selected pair mean slicer error
// - Save filtered error every 125000 symbols
// - Record highest peak filter value per window
// - Peak filter uses own gain, squares optionally
// - Peak scaled by shift plus three, cap 63
// - Capture loads peak; register keeps worst peak
// - Drop link only when index equals zero; code drops it in square mode only
// - Capture loads error; worst kept separately
// - Slicer error spans 32 or 64 maximum
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module cqm_top
  import cqm_pkg::*;
#(
  parameter int WINDOW_LEN = WINDOW_SYMBOLS // Symbols per measurement window
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic gig_mode_in,
  input wire logic sample_valid_in,
  input wire logic [PAIRS*ERR_W-1:0] slicer_err_in,
  output logic link_drop_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  // Window counter must fit and cover at least two symbols
  if (WINDOW_LEN < 2 || WINDOW_LEN >= (1 << WIN_W)) begin : g_bad_window
    $error("WINDOW_LEN out of range");
  end

  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_LEN - 1); // Last symbol count

  // All state of the block
  typedef struct packed {
    logic en; // Measurement enable
    logic sq; // Square mode
    logic [CH_W-1:0] ch; // Selected pair
    logic [SH_W-1:0] avg_gain; // average_gain_shift
    logic [SH_W-1:0] pk_gain; // peak_gain_shift
    logic [SH_W-1:0] mse_sh; // mse_scale_shift
    logic [SH_W-1:0] pk_sh; // peak_scale_shift
    logic [TH_N-1:0][TH_W-1:0] th; // quality_threshold_1..7 at index 0..6
    logic cap_pend; // Capture waits one cycle for the new pair number
    logic [TH_W-1:0] mean_square_error; // Captured mean square error
    logic [TH_W-1:0] mse_worst; // Largest error since last read
    logic [IDX_W-1:0] idx; // Captured quality index
    logic [IDX_W-1:0] idx_worst; // Lowest index since last read
    logic [SQ_W-1:0] mean; // Captured mean slicer error
    logic [PK_W-1:0] peak; // Captured peak error
    logic [PK_W-1:0] peak_worst; // Largest peak since last read
    logic rst_mse; // Worst error restarts on next save
    logic rst_idx; // Worst index restarts on next save
    logic rst_peak; // Worst peak restarts on next save
    logic [WIN_W-1:0] win_cnt; // Symbols in current window
    logic tick; // Window end pulse to the pair filters
    logic tick_d; // Saved values are fresh this cycle
    logic aw_have; // Write address held
    logic [ADDR_W-1:0] awaddr;
    logic w_have; // Write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic link_drop; // Quality based link loss
  } cqm_state_type;

  cqm_state_type s_ff;
  cqm_state_type nxt_s;

  logic [PAIRS-1:0][SQ_W-1:0] avg_saved; // Per pair averaging value
  logic [PAIRS-1:0][SQ_W-1:0] peak_saved; // Per pair window peak

  // One filter per cable pair
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    cqm_pair_filter u_filt (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clk_en_in(clk_en_in),
      .enable_in(s_ff.en),
      .square_in(s_ff.sq),
      .gig_in(gig_mode_in),
      .sample_valid_in(sample_valid_in),
      .slicer_err_in(slicer_err_in[p*ERR_W +: ERR_W]),
      .average_gain_shift_in(s_ff.avg_gain),
      .peak_gain_shift_in(s_ff.pk_gain),
      .window_tick_in(s_ff.tick),
      .avg_saved_out(avg_saved[p]),
      .peak_saved_out(peak_saved[p])
    );
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Threshold table lookup: later (better) levels override earlier ones
  function automatic logic [IDX_W-1:0] quality(input logic [TH_W-1:0] e,
      input logic [TH_N-1:0][TH_W-1:0] th);
    logic [IDX_W-1:0] q;
    q = IDX_WORST;
    for (int n = 0; n < TH_N; n++) begin
      if (e <= th[n]) begin
        q = IDX_W'(n + 1);
      end
    end
    return q;
  endfunction : quality

  // Live metrics of the selected pair
  logic [SQ_W-1:0] sel_avg;
  logic [SQ_W-1:0] sel_pk;
  logic [SQ_W-1:0] pk_div;
  logic [TH_W-1:0] mse_live;
  logic [IDX_W-1:0] idx_live;
  logic [PK_W-1:0] peak_live;

  // Scaling and saturation of the saved values
  always_comb begin
    sel_avg = avg_saved[s_ff.ch];
    sel_pk = peak_saved[s_ff.ch];
    // Scale into 0..511, capping when the divide is too small
    mse_live = ((sel_avg >> s_ff.mse_sh) > SQ_W'(MSE_MAX)) ? MSE_MAX
             : TH_W'(sel_avg >> s_ff.mse_sh);
    idx_live = quality(mse_live, s_ff.th);
    pk_div = sel_pk >> ({1'b0, s_ff.pk_sh} + PEAK_EXTRA_SHIFT);
    peak_live = (pk_div > SQ_W'(PEAK_MAX)) ? PEAK_MAX : pk_div[PK_W-1:0];
  end

  // Register read value for an address, and whether it is mapped
  function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a,
      input cqm_state_type s);
    logic [31:0] d;
    logic ok;
    d = '0;
    ok = 1'b1;
    case (a)
      REG_CONFIG: begin
        d[CFG_EN_BIT] = s.en;
        d[CFG_SQ_BIT] = s.sq;
        d[CFG_CH_LSB +: CH_W] = s.ch;
        d[CFG_AVG_LSB +: SH_W] = s.avg_gain;
        d[CFG_PKG_LSB +: SH_W] = s.pk_gain;
        d[CFG_MSES_LSB +: SH_W] = s.mse_sh;
        d[CFG_PKS_LSB +: SH_W] = s.pk_sh;
      end
      REG_MSE: d[TH_W-1:0] = s.mean_square_error;
      REG_MSE_WORST: d[TH_W-1:0] = s.mse_worst;
      REG_QUALITY: begin
        d[IDX_W-1:0] = s.idx;
        d[QUAL_WORST_LSB +: IDX_W] = s.idx_worst;
      end
      REG_MEAN_ERR: d[SQ_W-1:0] = s.mean;
      REG_PEAK: begin
        d[PK_W-1:0] = s.peak;
        d[PEAK_WORST_LSB +: PK_W] = s.peak_worst;
      end
      default: begin
        ok = 1'b0;
        for (int n = 0; n < TH_N; n++) begin
          if (a == REG_TH_BASE + ADDR_W'(4 * n)) begin
            d[TH_W-1:0] = s.th[n];
            ok = 1'b1;
          end
        end
      end
    endcase
    return {ok, d};
  endfunction : read_word

  // Bus handshakes: taken only while the clock enable lets state move
  assign s_axi_awready_out = clk_en_in & ~s_ff.aw_have & ~s_ff.bvalid;
  assign s_axi_wready_out = clk_en_in & ~s_ff.w_have & ~s_ff.bvalid;
  assign s_axi_arready_out = clk_en_in & ~s_ff.rvalid;

  // Next state of the whole block
  always_comb begin
    logic [32:0] rw;
    logic [31:0] wd;
    logic [ADDR_W-1:0] wa;
    logic wr_go;
    rw = '0;
    wd = '0;
    wa = '0;
    wr_go = 1'b0;
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    nxt_s.tick_d = s_ff.tick;
    nxt_s.cap_pend = 1'b0;

    // Window counter advances on symbols while enabled
    if (!s_ff.en) begin
      nxt_s.win_cnt = '0;
    end else if (sample_valid_in) begin
      if (s_ff.win_cnt == WIN_LAST) begin
        nxt_s.win_cnt = '0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.win_cnt = s_ff.win_cnt + WIN_W'(1);
      end
    end

    // Worst cases follow each save of the selected pair
    if (s_ff.tick_d) begin
      if (s_ff.rst_mse || mse_live > s_ff.mse_worst) begin
        nxt_s.mse_worst = mse_live;
      end
      if (s_ff.rst_idx || idx_live < s_ff.idx_worst) begin
        nxt_s.idx_worst = idx_live;
      end
      if (s_ff.rst_peak || peak_live > s_ff.peak_worst) begin
        nxt_s.peak_worst = peak_live;
      end
      nxt_s.rst_mse = 1'b0;
      nxt_s.rst_idx = 1'b0;
      nxt_s.rst_peak = 1'b0;
    end

    // Capture of the selected pair, a cycle after the request
    if (s_ff.cap_pend && s_ff.en) begin
      nxt_s.mean_square_error = mse_live;
      nxt_s.idx = idx_live;
      nxt_s.mean = sel_avg;
      nxt_s.peak = peak_live;
    end

    // Only a zero index in square mode drops the link
    nxt_s.link_drop = s_ff.en & s_ff.sq & (idx_live == IDX_WORST);

    // Write channel: address and data held in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      nxt_s.aw_have = 1'b1;
      nxt_s.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata = s_axi_wdata_in;
      nxt_s.wstrb = s_axi_wstrb_in;
    end
    wr_go = s_ff.aw_have & s_ff.w_have;
    if (wr_go) begin
      wa = s_ff.awaddr;
      rw = read_word(wa, s_ff);
      wd = merge(rw[31:0], s_ff.wdata, s_ff.wstrb);
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = rw[32] ? RESP_OKAY : RESP_SLVERR;
      if (wa == REG_CONFIG) begin
        nxt_s.en = wd[CFG_EN_BIT];
        nxt_s.sq = wd[CFG_SQ_BIT];
        nxt_s.ch = wd[CFG_CH_LSB +: CH_W];
        nxt_s.avg_gain = wd[CFG_AVG_LSB +: SH_W];
        nxt_s.pk_gain = wd[CFG_PKG_LSB +: SH_W];
        nxt_s.mse_sh = wd[CFG_MSES_LSB +: SH_W];
        nxt_s.pk_sh = wd[CFG_PKS_LSB +: SH_W];
        // Capture bit is not stored, so it reads back as cleared at once
        nxt_s.cap_pend = s_ff.wstrb[0] & s_ff.wdata[CFG_CAP_BIT];
      end
      for (int n = 0; n < TH_N; n++) begin
        if (wa == REG_TH_BASE + ADDR_W'(4 * n)) begin
          nxt_s.th[n] = wd[TH_W-1:0];
        end
      end
    end
    if (s_ff.bvalid && s_axi_bready_in) begin
      nxt_s.bvalid = 1'b0;
    end

    // Read channel: one cycle to the answer; worst reads restart tracking
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rw = read_word(s_axi_araddr_in, s_ff);
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rw[31:0];
      nxt_s.rresp = rw[32] ? RESP_OKAY : RESP_SLVERR;
      // Overrides a save in this cycle, so the next save still restarts
      if (s_axi_araddr_in == REG_MSE_WORST) begin
        nxt_s.rst_mse = 1'b1;
      end
      if (s_axi_araddr_in == REG_QUALITY) begin
        nxt_s.rst_idx = 1'b1;
      end
      if (s_axi_araddr_in == REG_PEAK) begin
        nxt_s.rst_peak = 1'b1;
      end
    end else if (s_ff.rvalid && s_axi_rready_in) begin
      nxt_s.rvalid = 1'b0;
    end
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_ff <= '0;
      s_ff.th <= {TH_N{TH_RST}};
      s_ff.avg_gain <= SHIFT_RST;
      s_ff.pk_gain <= SHIFT_RST;
      s_ff.mse_sh <= SHIFT_RST;
      s_ff.pk_sh <= SHIFT_RST;
      s_ff.idx <= IDX_BEST;
      s_ff.idx_worst <= IDX_BEST;
      s_ff.rst_mse <= 1'b1;
      s_ff.rst_idx <= 1'b1;
      s_ff.rst_peak <= 1'b1;
    end else if (clk_en_in) begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign link_drop_out = s_ff.link_drop;
  assign s_axi_bvalid_out = s_ff.bvalid;
  assign s_axi_bresp_out = s_ff.bresp;
  assign s_axi_rvalid_out = s_ff.rvalid;
  assign s_axi_rdata_out = s_ff.rdata;
  assign s_axi_rresp_out = s_ff.rresp;
endmodule : cqm_top

// ---- bench/cqm_slicer_model.sv ----
// Receive slicer stand-in: one error per pair per symbol, with optional gaps
`timescale 1ns/1ps
module cqm_slicer_model
  import cqm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic [1:0] gap_in,
  input wire logic [PAIRS*ERR_W-1:0] err_in,
  output logic sample_valid_out,
  output logic [PAIRS*ERR_W-1:0] slicer_err_out
);
  logic [1:0] idle_ff; // Idle cycles left before the next symbol
  // One symbol every gap_in+1 cycles; data scrambled in between
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_ff <= 2'h0;
      sample_valid_out <= 1'b0;
      slicer_err_out <= '0;
    end else if (run_in && idle_ff == 2'h0) begin
      idle_ff <= gap_in;
      sample_valid_out <= 1'b1;
      slicer_err_out <= err_in;
    end else begin
      idle_ff <= (idle_ff == 2'h0) ? 2'h0 : idle_ff - 2'h1;
      sample_valid_out <= 1'b0;
      slicer_err_out <= ~slicer_err_out;
    end
  end
endmodule : cqm_slicer_model

// ---- bench/cqm_top_sva.sv ----
// Register bus assertions for the quality metrics block
`timescale 1ns/1ps
module cqm_top_sva
  import cqm_pkg::*;
(
  input logic clk_in,
  input logic reset_n_in,
  input logic clk_en_in,
  input logic s_axi_awvalid_in,
  input logic s_axi_awready_out,
  input logic s_axi_wvalid_in,
  input logic s_axi_wready_out,
  input logic [1:0] s_axi_bresp_out,
  input logic s_axi_bvalid_out,
  input logic s_axi_bready_in,
  input logic [ADDR_W-1:0] s_axi_araddr_in,
  input logic s_axi_arvalid_in,
  input logic s_axi_arready_out,
  input logic [31:0] s_axi_rdata_out,
  input logic [1:0] s_axi_rresp_out,
  input logic s_axi_rvalid_out,
  input logic s_axi_rready_in
);
  logic [ADDR_W-1:0] rd_addr_ff; // Register the pending read answers for
  logic unmapped; // Pending read lies outside the map
  // A frozen clock enable stretches every latency, so it aborts checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in || !clk_en_in);
  // Read address at its handshake
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rd_addr_ff <= '0;
    else if (s_axi_arvalid_in && s_axi_arready_out) rd_addr_ff <= s_axi_araddr_in;
  end
  assign unmapped = (rd_addr_ff > REG_PEAK && rd_addr_ff < REG_TH_BASE) || rd_addr_ff > 8'h38;
  write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##1 !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write answer timing");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  write_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  read_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
    && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)) else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read overlap");
  write_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write overlap");
  capture_clear_a: assert property (
    s_axi_rvalid_out && rd_addr_ff == REG_CONFIG |-> !s_axi_rdata_out[CFG_CAP_BIT])
    else $error("capture bit set");
  mse_range_a: assert property (
    s_axi_rvalid_out && rd_addr_ff == REG_MSE |-> s_axi_rdata_out[31:TH_W] == '0)
    else $error("mse range");
  peak_range_a: assert property (
    s_axi_rvalid_out && rd_addr_ff == REG_PEAK |-> s_axi_rdata_out[7:6] == 2'h0
    && s_axi_rdata_out[31:14] == '0) else $error("peak range");
  unmapped_read_a: assert property (s_axi_rvalid_out && unmapped |->
    s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == '0) else $error("unmapped read");
endmodule : cqm_top_sva
bind cqm_top cqm_top_sva u_cqm_sva (.*);

// ---- bench/test_channel_quality_metrics.sv ----
// Self-checking bench for the channel quality metrics block
`timescale 1ns/1ps
module test_channel_quality_metrics
  import cqm_pkg::*;
;
  logic clk_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1, gig_mode_in = 1'b0, run = 1'b0;
  logic sample_valid_in, link_drop_out;
  logic [PAIRS*ERR_W-1:0] slicer_err_in, err_bus = '0;
  logic [1:0] gap = 2'h0, s_axi_bresp_out, s_axi_rresp_out, r;
  logic [ADDR_W-1:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out, d;
  logic [3:0] s_axi_wstrb_in = 4'hf; // Whole words only
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out;
  int fail_count = 0, checked = 0, th[8], e[PAIRS], p, x, st, ms, ps;
  bit g, s;
  // Short window keeps the run brief
  cqm_top #(.WINDOW_LEN(16)) dut (.*);
  cqm_slicer_model u_slicer (.clk_in, .reset_n_in, .run_in(run), .gap_in(gap),
    .err_in(err_bus), .sample_valid_out(sample_valid_in), .slicer_err_out(slicer_err_in));
  always #2.5 clk_in = ~clk_in;
  // Filter input: magnitude, doubled at gigabit, maybe squared
  function automatic int fx(int v, bit gi, bit sq);
    int m;
    m = v < 0 ? -v : v;
    m = gi ? m * 2 : m;
    m = m > 64 ? 64 : m;
    return sq ? m * m : m;
  endfunction : fx
  function automatic int fmse(int v, int sh);
    return (v >> sh) > 511 ? 511 : v >> sh;
  endfunction : fmse
  // Highest index whose threshold is not exceeded
  function automatic int fidx(int m);
    for (int n = 7; n >= 1; n--) begin
      if (m <= th[n]) return n;
    end
    return 0;
  endfunction : fidx
  function automatic int fpk(int v, int sh);
    return (v >> (sh + 3)) > 63 ? 63 : v >> (sh + 3);
  endfunction : fpk
  function automatic logic [31:0] cfg(bit en, bit sq, int pr, bit cap, int ag, int pg);
    return {8'h0, 4'(ps), 4'(ms), 4'(pg), 4'(ag), 3'h0, cap, 2'(pr), sq, en};
  endfunction : cfg
  task automatic give_verdict;
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Bounded wait ran out: count it and stop
  task automatic hang(input string m);
    chk(34'h1, 34'h0, m);
    give_verdict();
  endtask : hang
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    int n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1 && n < 200);
    if (n >= 200) hang("write hang");
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1 && n < 200);
    if (n >= 200) hang("read hang");
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge clk_in);
  endtask : rd
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [31:0] mk = '1);
    rd(a);
    chk({r, d & mk}, {RESP_OKAY, v}, $sformatf("read %h", a));
  endtask : rc
  task automatic wait_sym(input int k);
    int n = 0, c = 0;
    while (c < k) begin
      @(posedge clk_in);
      if (sample_valid_in === 1'b1) c++;
      if (++n > 1000) hang("no symbols");
    end
  endtask : wait_sym
  // Capture, then let results land
  task automatic capture(input bit en, input bit sq, input int ag);
    wr(REG_CONFIG, cfg(en, sq, p, 1'b1, ag, ag));
    repeat (2) @(posedge clk_in);
  endtask : capture
  initial begin
    void'($urandom(32'ha945));
    ms = 0;
    ps = 0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rc(REG_CONFIG, 32'h0);
    rc(REG_QUALITY, 32'h77);
    rc(REG_MSE, 32'h0);
    rd(8'h18);
    chk({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h1c, 32'hffffffff);
    chk({r, 32'h0}, {RESP_SLVERR, 32'h0}, "unmapped write");
    // Falling thresholds keep the table ordered
    st = $urandom_range(1, 63);
    for (int n = 1; n <= TH_N; n++) begin
      th[n] = (8 - n) * st;
      wr(8'(REG_TH_BASE + 4 * (n - 1)), th[n]);
      rc(8'(REG_TH_BASE + 4 * (n - 1)), th[n], 32'h1ff);
    end
    // Worst held over bad then good line; restart is pending from reset
    p = $urandom_range(0, 3);
    err_bus[p*ERR_W +: ERR_W] <= 8'hc0;
    run <= 1'b1;
    wr(REG_CONFIG, cfg(1'b1, 1'b1, p, 1'b0, 0, 0));
    wait_sym(48);
    chk(34'(link_drop_out), 34'h1, "no drop");
    err_bus[p*ERR_W +: ERR_W] <= 8'h01;
    wait_sym(48);
    chk(34'(link_drop_out), 34'h0, "good drop");
    capture(1'b1, 1'b1, 0);
    rc(REG_CONFIG, cfg(1'b1, 1'b1, p, 1'b0, 0, 0));
    rc(REG_MSE, 32'h1);
    rc(REG_MSE_WORST, 32'h1ff);
    rc(REG_QUALITY, 32'h07);
    rc(REG_PEAK, 32'h3f00);
    wait_sym(48);
    rc(REG_MSE_WORST, 32'h1);
    rc(REG_QUALITY, 32'h77);
    rc(REG_PEAK, 32'h0);
    // Disabled: no drop, capture inert
    err_bus[p*ERR_W +: ERR_W] <= 8'hc0;
    wr(REG_CONFIG, cfg(1'b0, 1'b1, p, 1'b0, 0, 0));
    wait_sym(48);
    chk(34'(link_drop_out), 34'h0, "off drop");
    capture(1'b0, 1'b1, 0);
    rc(REG_MSE, 32'h1);
    // Slowest gains stay near zero
    wr(REG_CONFIG, cfg(1'b1, 1'b0, p, 1'b0, 15, 15));
    wait_sym(40);
    capture(1'b1, 1'b0, 15);
    rc(REG_MEAN_ERR, 32'h0);
    rc(REG_PEAK, 32'h0, 32'h3f);
    // Random pairs, modes, scales, pacing
    for (int i = 0; i < 8; i++) begin
      g = 1'($urandom_range(0, 1));
      s = 1'($urandom_range(0, 1));
      p = $urandom_range(0, 3);
      ms = $urandom_range(0, 7);
      ps = $urandom_range(0, 3);
      for (int q = 0; q < PAIRS; q++) begin
        e[q] = int'($urandom_range(0, g ? 64 : 128)) - (g ? 32 : 64);
        err_bus[q*ERR_W +: ERR_W] <= 8'(e[q]);
      end
      gig_mode_in <= g;
      gap <= 2'($urandom_range(0, 3));
      wr(REG_CONFIG, cfg(1'b1, s, p, 1'b0, 0, 0));
      wait_sym(48);
      capture(1'b1, s, 0);
      x = fx(e[p], g, s);
      rc(REG_MSE, fmse(x, ms), 32'h1ff);
      rc(REG_MEAN_ERR, x, 32'h1fff);
      rc(REG_QUALITY, fidx(fmse(x, ms)), 32'h7);
      rc(REG_PEAK, fpk(x, ps), 32'h3f);
    end
    give_verdict();
  end
endmodule : test_channel_quality_metrics
